//--- rtl/gpio_port.sv
// Two-pin general-purpose port with pull-up and APB register access
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module gpio_port #(
  parameter int unsigned DATA_W = gpio_port_pkg::APB_DATA_W,
  parameter int unsigned ADDR_W = gpio_port_pkg::APB_ADDR_W
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [DATA_W-1:0] i_pwdata,
  input wire logic [DATA_W/8-1:0] i_pstrb,
  input wire logic i_rmw_read,
  input wire logic i_stop_mode,
  input wire logic i_watch_mode,
  input wire logic [gpio_port_pkg::PORT_W-1:0] i_pad_in,
  output logic o_pready,
  output logic o_pslverr,
  output logic [DATA_W-1:0] o_prdata,
  output logic [gpio_port_pkg::PORT_W-1:0] o_pad_out,
  output logic [gpio_port_pkg::PORT_W-1:0] o_pad_oe,
  output logic [gpio_port_pkg::PORT_W-1:0] o_pullup_en
);
  import gpio_port_pkg::*;

  // Elaboration-time refusal of bus widths the decode cannot serve
  generate
    if (DATA_W != APB_DATA_W) begin : g_bad_data_w
      $error("gpio_port supports a 32-bit data bus only");
    end
    if (ADDR_W != APB_ADDR_W) begin : g_bad_addr_w
      $error("gpio_port needs the package address width");
    end
  endgenerate

  // Register state
  logic [PORT_W-1:0] out_latch_ff;
  logic [PORT_W-1:0] direction_ff;
  logic [PORT_W-1:0] pullup_select_ff;
  logic standby_pin_float_ff;
  logic standby_active_ff;
  logic float_ff;

  // Bus handshake state
  apb_state_type apb_state_ff;
  apb_state_type nxt_apb_state;
  logic pready_ff;
  logic pslverr_ff;
  logic [DATA_W-1:0] prdata_ff;
  logic nxt_pslverr;
  logic [DATA_W-1:0] nxt_prdata;

  // Decoded access
  logic sel_out_latch;
  logic sel_direction;
  logic sel_pullup_select;
  logic sel_standby_control;
  logic addr_hit;
  logic wr_commit;
  logic lane0_en;

  // Per-pin cell results
  logic [PORT_W-1:0] cell_pad_out;
  logic [PORT_W-1:0] cell_pad_oe;
  logic [PORT_W-1:0] cell_pullup_en;
  logic [PORT_W-1:0] cell_level;
  logic [PORT_W-1:0] latch_view;

  // Address decode on word-aligned offsets
  always_comb begin
    sel_out_latch = (i_paddr == OFS_OUT_LATCH);
    sel_direction = (i_paddr == OFS_DIRECTION);
    sel_pullup_select = (i_paddr == OFS_PULLUP_SELECT);
    sel_standby_control = (i_paddr == OFS_STANDBY_CONTROL);
    addr_hit = sel_out_latch | sel_direction | sel_pullup_select | sel_standby_control;
  end

  // A write takes effect at the edge where the access completes
  always_comb begin
    wr_commit = i_psel & i_penable & pready_ff & i_pwrite & addr_hit;
    lane0_en = i_pstrb[0];
  end

  // Bus handshake: one wait state, answer registered
  always_comb begin
    nxt_apb_state = apb_state_ff;
    case (apb_state_ff)
      APB_IDLE: begin
        if (i_psel && !i_penable) begin
          nxt_apb_state = APB_WAIT;
        end
      end
      APB_WAIT: begin
        if (i_psel && i_penable) begin
          nxt_apb_state = APB_RESP;
        end else if (!i_psel) begin
          nxt_apb_state = APB_IDLE;
        end
      end
      APB_RESP: begin
        nxt_apb_state = APB_IDLE;
      end
      default: begin
        nxt_apb_state = APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      apb_state_ff <= APB_IDLE;
    end else begin
      apb_state_ff <= nxt_apb_state;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= (apb_state_ff == APB_WAIT) & i_psel & i_penable;
    end
  end

  // Latch view: output pins and RMW reads see the latch, others see the pad
  always_comb begin
    for (int b = 0; b < PORT_W; b++) begin
      if (direction_ff[b] || i_rmw_read) begin
        latch_view[b] = out_latch_ff[b];
      end else begin
        latch_view[b] = cell_level[b];
      end
    end
  end

  // Read data and error answer, prepared during the wait state
  always_comb begin
    nxt_prdata = '0;
    nxt_pslverr = 1'b0;
    if (!addr_hit) begin
      nxt_pslverr = 1'b1;
    end else if (!i_pwrite) begin
      if (sel_out_latch) begin
        nxt_prdata[PORT_W-1:0] = latch_view & PIN_MASK;
      end
      if (sel_direction) begin
        nxt_prdata[PORT_W-1:0] = direction_ff & PIN_MASK;
      end
      if (sel_pullup_select) begin
        nxt_prdata[PORT_W-1:0] = pullup_select_ff & PIN_MASK;
      end
      if (sel_standby_control) begin
        nxt_prdata[STBY_FLOAT_POS] = standby_pin_float_ff;
        nxt_prdata[STBY_ACTIVE_POS] = standby_active_ff;
        nxt_prdata[STBY_FLOATING_POS] = float_ff;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      prdata_ff <= '0;
      pslverr_ff <= 1'b0;
    end else if ((apb_state_ff == APB_WAIT) && i_psel && i_penable) begin
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end else begin
      prdata_ff <= '0;
      pslverr_ff <= 1'b0;
    end
  end

  // Output latch: every write with byte lane 0 enabled is stored whatever the direction
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      out_latch_ff <= RST_OUT_LATCH;
    end else if (wr_commit && sel_out_latch && lane0_en) begin
      out_latch_ff <= i_pwdata[PORT_W-1:0] & PIN_MASK;
    end
  end

  // Direction register, cleared at reset so all pins start as inputs
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      direction_ff <= RST_DIRECTION;
    end else if (wr_commit && sel_direction && lane0_en) begin
      direction_ff <= i_pwdata[PORT_W-1:0] & PIN_MASK;
    end
  end

  // Pull-up select register
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pullup_select_ff <= RST_PULLUP_SELECT;
    end else if (wr_commit && sel_pullup_select && lane0_en) begin
      pullup_select_ff <= i_pwdata[PORT_W-1:0] & PIN_MASK;
    end
  end

  // Standby pin-float control bit
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      standby_pin_float_ff <= RST_STANDBY_PIN_FLOAT;
    end else if (wr_commit && sel_standby_control && lane0_en) begin
      standby_pin_float_ff <= i_pwdata[STBY_FLOAT_POS];
    end
  end

  // Standby tracking: floating only with the float bit set
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      standby_active_ff <= 1'b0;
      float_ff <= 1'b0;
    end else begin
      standby_active_ff <= i_stop_mode | i_watch_mode;
      float_ff <= (i_stop_mode | i_watch_mode) & standby_pin_float_ff;
    end
  end

  // Pin cells for implemented bits only
  generate
    for (genvar g = 0; g < PORT_W; g++) begin : g_pin
      if (PIN_MASK[g]) begin : g_used
        gpio_pin_cell u_cell (
          .i_clk(i_clk),
          .i_rst_b(i_rst_b),
          .i_latch(out_latch_ff[g]),
          .i_dir(direction_ff[g]),
          .i_pullup_sel(pullup_select_ff[g]),
          .i_float(float_ff),
          .i_pad_in(i_pad_in[g]),
          .o_pad_out(cell_pad_out[g]),
          .o_pad_oe(cell_pad_oe[g]),
          .o_pullup_en(cell_pullup_en[g]),
          .o_level(cell_level[g])
        );
      end else begin : g_unused
        assign cell_pad_out[g] = 1'b0;
        assign cell_pad_oe[g] = 1'b0;
        assign cell_pullup_en[g] = 1'b0;
        assign cell_level[g] = 1'b0;
      end
    end
  endgenerate

  // Outputs come from flip-flops in this module or in the pin cells; unimplemented pin bits are tied low
  assign o_pready = pready_ff;
  assign o_pslverr = pslverr_ff;
  assign o_prdata = prdata_ff;
  assign o_pad_out = cell_pad_out;
  assign o_pad_oe = cell_pad_oe;
  assign o_pullup_en = cell_pullup_en;
endmodule

//--- pkg/gpio_port_pkg.sv
// Shared constants for the two-pin general-purpose port
package gpio_port_pkg;
  localparam int unsigned APB_ADDR_W = 12;
  localparam int unsigned APB_DATA_W = 32;
  localparam int unsigned PORT_W = 8;
  localparam logic [APB_ADDR_W-1:0] OFS_OUT_LATCH = 12'h000;
  localparam logic [APB_ADDR_W-1:0] OFS_DIRECTION = 12'h004;
  localparam logic [APB_ADDR_W-1:0] OFS_PULLUP_SELECT = 12'h008;
  localparam logic [APB_ADDR_W-1:0] OFS_STANDBY_CONTROL = 12'h00c;
  localparam int unsigned PIN_ONE_POS = 1;
  localparam int unsigned PIN_TWO_POS = 2;
  localparam logic [PORT_W-1:0] PIN_MASK = 8'h06;
  localparam logic [PORT_W-1:0] RST_OUT_LATCH = 8'h00;
  localparam logic [PORT_W-1:0] RST_DIRECTION = 8'h00;
  localparam logic [PORT_W-1:0] RST_PULLUP_SELECT = 8'h00;
  localparam logic RST_STANDBY_PIN_FLOAT = 1'b0;
  localparam int unsigned STBY_FLOAT_POS = 0;
  localparam int unsigned STBY_ACTIVE_POS = 1;
  localparam int unsigned STBY_FLOATING_POS = 2;
  localparam int unsigned APB_WAIT_CYCLES = 1;
  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_WAIT = 2'b01,
    APB_RESP = 2'b11
  } apb_state_type;
endpackage

//--- rtl/gpio_pin_cell.sv
// One port pin: output drive, enable, pull-up and input gating
`timescale 1ns/1ps
module gpio_pin_cell (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_latch,
  input wire logic i_dir,
  input wire logic i_pullup_sel,
  input wire logic i_float,
  input wire logic i_pad_in,
  output logic o_pad_out,
  output logic o_pad_oe,
  output logic o_pullup_en,
  output logic o_level
);
  logic nxt_oe;
  logic nxt_pullup;

  always_comb begin
    nxt_oe = i_dir & ~i_float;
    nxt_pullup = i_pullup_sel & ~(nxt_oe & ~i_latch);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_pad_oe <= 1'b0;
      o_pad_out <= 1'b0;
      o_pullup_en <= 1'b0;
    end else begin
      o_pad_oe <= nxt_oe;
      o_pad_out <= nxt_oe & i_latch;
      o_pullup_en <= nxt_pullup;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_level <= 1'b0;
    end else begin
      o_level <= i_pad_in & ~i_float;
    end
  end
endmodule

//--- testbench/gpio_port_chk.sv
// Checker for the two-pin port
`timescale 1ns/1ps
module gpio_port_chk
  import gpio_port_pkg::*;
#(
  parameter int unsigned DATA_W = 32,
  parameter int unsigned ADDR_W = 12
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [DATA_W-1:0] i_pwdata,
  input wire logic [DATA_W/8-1:0] i_pstrb,
  input wire logic i_stop_mode,
  input wire logic i_watch_mode,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [DATA_W-1:0] o_prdata,
  input wire logic [PORT_W-1:0] o_pad_out,
  input wire logic [PORT_W-1:0] o_pad_oe,
  input wire logic [PORT_W-1:0] o_pullup_en
);
  logic [7:0] dir_ff, lat_ff, pu_ff;
  logic flt_ff;
  logic wr_ok;
  assign wr_ok = i_psel && i_penable && i_pwrite && o_pready && !o_pslverr && i_pstrb[0];
  // Shadow copies of the written registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      dir_ff <= 8'h00;
      lat_ff <= 8'h00;
      pu_ff <= 8'h00;
      flt_ff <= 1'b0;
    end else if (wr_ok) begin
      if (i_paddr == OFS_DIRECTION) dir_ff <= i_pwdata[7:0] & PIN_MASK;
      if (i_paddr == OFS_OUT_LATCH) lat_ff <= i_pwdata[7:0] & PIN_MASK;
      if (i_paddr == OFS_PULLUP_SELECT) pu_ff <= i_pwdata[7:0] & PIN_MASK;
      if (i_paddr == OFS_STANDBY_CONTROL) flt_ff <= i_pwdata[0];
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_live;
    !(flt_ff && (i_stop_mode || i_watch_mode)) ##1 1'b1;
  endsequence
  AST_PIN_MAP: assert property (((o_pad_oe | o_pad_out | o_pullup_en) & ~PIN_MASK) == 8'h00)
    else $error("output on unimplemented bit");
  AST_LOW_NO_PULLUP: assert property ((o_pad_oe & ~o_pad_out & o_pullup_en) == 8'h00)
    else $error("pull-up on pin driven low");
  AST_READY_ONE: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  AST_READY_TIME: assert property ((i_psel && !i_penable) |-> ##2 o_pready)
    else $error("pready not two cycles after setup");
  AST_IDLE_QUIET: assert property (!o_pready |-> (o_prdata == '0 && !o_pslverr))
    else $error("read data outside pready");
  AST_DIR_OE: assert property (s_live |=> o_pad_oe == $past(dir_ff))
    else $error("pad enable differs from direction");
  AST_OUT_LATCH: assert property (s_live |=> o_pad_out == $past(dir_ff & lat_ff))
    else $error("pad level differs from latch");
  AST_PULLUP: assert property (s_live |=> o_pullup_en == $past(pu_ff & ~(dir_ff & ~lat_ff)))
    else $error("pull-up differs from select");
  AST_FLOAT: assert property ((flt_ff && (i_stop_mode || i_watch_mode)) |-> ##2 o_pad_oe == 8'h00)
    else $error("pin driven while floating");
  cover property (flt_ff && i_stop_mode);
  cover property (o_pslverr);
  cover property (o_pad_oe == PIN_MASK);
endmodule
bind gpio_port gpio_port_chk #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) chk_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .i_pstrb(i_pstrb), .i_stop_mode(i_stop_mode), .i_watch_mode(i_watch_mode), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_prdata(o_prdata), .o_pad_out(o_pad_out), .o_pad_oe(o_pad_oe),
  .o_pullup_en(o_pullup_en));

//--- testbench/gpio_board_model.sv
// Board model on the port pins
`timescale 1ns/1ps
module gpio_board_model (
  input wire logic i_clk,
  input wire logic [7:0] i_pad_out,
  input wire logic [7:0] i_pad_oe,
  input wire logic [7:0] i_pullup_en,
  input wire logic [7:0] i_ext_en,
  input wire logic [7:0] i_ext_val,
  output logic [7:0] o_level
);
  logic [7:0] last_ff = 8'h00;
  always_ff @(posedge i_clk) begin
    last_ff <= o_level;
  end
  // No oscillator drives the pins; the shared output stays off
  // A released, unpulled pin toggles so no level is assumed
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (i_pad_oe[b]) o_level[b] = i_pad_out[b];
      else if (i_ext_en[b]) o_level[b] = i_ext_val[b];
      else if (i_pullup_en[b]) o_level[b] = 1'b1;
      else o_level[b] = ~last_ff[b];
    end
  end
endmodule

//--- testbench/tb.sv
// Self-checking bench for the two-pin port
`timescale 1ns/1ps
module tb;
  import gpio_port_pkg::*;
  logic i_clk, i_rst_b, psel, penable, pwrite, rmw, stop, watch, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] pad_out, pad_oe, pull, level, ext_en, ext_val;
  int fails = 0;
  int tests_run = 0;
  gpio_port DUT (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .i_rmw_read(rmw), .i_stop_mode(stop),
    .i_watch_mode(watch), .i_pad_in(level), .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata),
    .o_pad_out(pad_out), .o_pad_oe(pad_oe), .o_pullup_en(pull));
  gpio_board_model board (.i_clk(i_clk), .i_pad_out(pad_out), .i_pad_oe(pad_oe), .i_pullup_en(pull),
    .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(level));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      fails++;
      $display("unexpected %s exp %h got %h", nm, ex, got);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic m,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    rmw <= m;
    @(posedge i_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    rmw <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, 1'b0, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic m, input logic [31:0] ex);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h0, m, r, e);
    chk("read data", ex, r);
    chk("read pslverr", 32'h0, {31'h0, e});
  endtask
  task automatic t_output();
    wr(OFS_DIRECTION, 32'h0000_00ff);
    wr(OFS_OUT_LATCH, 32'h0000_0004);
    wr(OFS_PULLUP_SELECT, 32'h0000_0006);
    repeat (3) @(posedge i_clk);
    chk("pad_oe", 32'h6, pad_oe);
    chk("pad_out", 32'h4, pad_out);
    chk("pullup", 32'h4, pull);
    rd(OFS_DIRECTION, 1'b0, 32'h6);
    rd(OFS_OUT_LATCH, 1'b0, 32'h4);
    $display("test output done");
  endtask
  task automatic t_input();
    ext_en <= 8'h06;
    ext_val <= 8'h02;
    wr(OFS_DIRECTION, 32'h0);
    wr(OFS_OUT_LATCH, 32'h6);
    repeat (3) @(posedge i_clk);
    chk("pad_oe", 32'h0, pad_oe);
    chk("pullup", 32'h6, pull);
    rd(OFS_OUT_LATCH, 1'b0, 32'h2);
    rd(OFS_OUT_LATCH, 1'b1, 32'h6);
    $display("test input done");
  endtask
  task automatic t_standby();
    logic [31:0] r;
    logic e;
    wr(OFS_STANDBY_CONTROL, 32'h1);
    stop <= 1'b1;
    repeat (3) @(posedge i_clk);
    rd(OFS_OUT_LATCH, 1'b0, 32'h0);
    ext_en <= 8'h00;
    wr(OFS_DIRECTION, 32'h6);
    repeat (3) @(posedge i_clk);
    chk("pad_oe", 32'h0, pad_oe);
    stop <= 1'b0;
    watch <= 1'b1;
    wr(OFS_STANDBY_CONTROL, 32'h0);
    repeat (3) @(posedge i_clk);
    chk("pad_oe", 32'h6, pad_oe);
    chk("pad_out", 32'h6, pad_out);
    watch <= 1'b0;
    apb(12'h010, 1'b0, 32'h0, 1'b0, r, e);
    chk("pslverr", 32'h1, {31'h0, e});
    $display("test standby done");
  endtask
  initial begin
    repeat (5000) @(posedge i_clk);
    fails++;
    final_report();
  end
  initial begin
    {i_rst_b, psel, penable, pwrite, rmw, stop, watch} = 7'h00;
    {paddr, pwdata, ext_en, ext_val} = '0;
    pstrb = 4'hf;
    repeat (10) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    chk("pad_oe", 32'h0, pad_oe);
    rd(OFS_DIRECTION, 1'b0, 32'h0);
    t_output();
    t_input();
    t_standby();
    final_report();
  end
endmodule
